// ### rtl/uspi_engine.sv
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uspi_params.svh"
// How it works
// (RULE_01) synchronous shift engine runs only while the sync mode bit is one
// (RULE_02) characters are seven or eight bits, separate receive and transmit buffers
// (RULE_03) seven-bit mode reads the receive buffer top bit as zero
// (RULE_04) master select bit set makes us drive the shift clock
// (RULE_05) master launches bit in first half, samples at mid-period
// (RULE_06) transmit buffer moves to empty shifter, shifted out msb first
// (RULE_07) receive msb first, store right-justified, raise receive done
// (RULE_08) new character over an unread one raises overrun
// (RULE_09) master receives only by transmitting, both directions together
// (RULE_10) master idles two internal cycles between characters
// (RULE_11) four-pin master shifts only while bus select is high
// (RULE_12) four-pin master, select low: release drivers, flag conflict and receive done
// (RULE_13) select high again restores driver directions
// (RULE_14) three-pin mode ignores bus select in both roles
// (RULE_15) slave takes shift clock from the pin, divider unused
// (RULE_16) slave shifts out preloaded character, captures on opposite edge
// (RULE_17) four-pin slave shifts only while bus select is low
// (RULE_18) four-pin slave freezes mid-character while select high, then resumes
// (RULE_19) four-pin slave releases its output while select is high
// (RULE_20) external master supplies clock and drives select low for us
// (RULE_21) transmit empty flag follows the holding buffer state
// (RULE_22) receive done clears when the receive buffer is read
// (RULE_23) one link enable bit gates receiver and transmitter together
// (RULE_24) clock polarity and phase pick launch and sample edges in both roles
module uspi_engine
    import uspi_pkg::*;
(
    input wire logic ref_clk, // core clock, 125 mhz
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic sclkIn, // shift clock pin level
    output logic sclkOut, // shift clock drive value
    output logic sclkOe, // shift clock drive enable
    input wire logic mosiIn, // master-to-slave pin level
    output logic mosiOut, // master-to-slave drive value
    output logic mosiOe, // master-to-slave drive enable
    input wire logic misoIn, // slave-to-master pin level
    output logic misoOut, // slave-to-master drive value
    output logic misoOe, // slave-to-master drive enable
    input wire logic busSelIn // bus select pin level
);
    uspi_core_s core_ff;
    uspi_core_s nxt_core;
    uspi_reg_if regIf ();
    logic [3:0] pinsS;
    logic sclkS;
    logic mosiS;
    logic misoS;
    logic steS;
    logic syncMode;
    logic isMaster;
    logic char8;
    logic fourPin;
    logic linkEn;
    logic cpol;
    logic cpha;
    logic [7:0] divVal;
    logic masterRun;
    logic slaveSel;
    logic masterOn;
    logic slaveOn;
    logic conflict;
    logic tick;
    logic slvEdge;
    logic edgeEv;
    logic leading;
    logic rxIn;
    logic [4:0] lastEdge;
    logic charDone;
    logic deliver;
    logic [7:0] rxNew;

    // shift clock polarity and phase: sample on leading edge when phase is zero
    function automatic logic sampleEdge(input logic lead, input logic ph);
        return lead ^ ph; // RULE_24
    endfunction

    function automatic logic [4:0] lastEdgeOf(input logic c8);
        return c8 ? `USPI_LAST_EDGE8 : `USPI_LAST_EDGE7;
    endfunction

    function automatic logic [7:0] rightJust(input logic [7:0] v, input logic c8);
        return c8 ? v : {1'b0, v[6:0]};
    endfunction

    uspi_apb u_apb (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regIf(regIf)
    );

    // every pin level is two flops away from the engine
    uspi_sync #(.W(4)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d({busSelIn, misoIn, mosiIn, sclkIn}),
        .q(pinsS)
    );
    assign sclkS = pinsS[0];
    assign mosiS = pinsS[1];
    assign misoS = pinsS[2];
    assign steS = pinsS[3];

    // control decode
    assign syncMode = core_ff.ctrl[`USPI_CTRL_SYNC];
    assign isMaster = core_ff.ctrl[`USPI_CTRL_MASTER];
    assign char8 = core_ff.ctrl[`USPI_CTRL_CHAR8];
    assign fourPin = core_ff.ctrl[`USPI_CTRL_FOURPIN];
    assign linkEn = core_ff.ctrl[`USPI_CTRL_LINKEN];
    assign cpol = core_ff.ctrl[`USPI_CTRL_CPOL];
    assign cpha = core_ff.ctrl[`USPI_CTRL_CPHA];
    assign divVal = core_ff.ctrl[`USPI_CTRL_DIV_LSB +: 8];

    // bus select qualification; three-pin mode never looks at it
    assign masterRun = !fourPin || steS; // RULE_11 RULE_14
    assign slaveSel = !fourPin || !steS; // RULE_17 RULE_14
    assign masterOn = syncMode && isMaster; // RULE_01 RULE_04
    assign slaveOn = syncMode && !isMaster && linkEn && slaveSel; // RULE_15 RULE_23 RULE_18
    assign conflict = masterOn && fourPin && !steS;

    // edge events: master from its divider, slave from the pin
    assign tick = masterOn && masterRun && core_ff.state == ST_SHIFT && core_ff.divCnt == 8'h00;
    assign slvEdge = slaveOn && sclkS != core_ff.sclkPrev; // RULE_15
    assign edgeEv = tick || slvEdge;
    assign leading = isMaster ? core_ff.sclk == cpol : sclkS != cpol;
    assign rxIn = isMaster ? misoS : mosiS;
    assign lastEdge = lastEdgeOf(char8);
    assign charDone = edgeEv && core_ff.edgeCnt == lastEdge;
    assign rxNew = sampleEdge(leading, cpha) ? {core_ff.rxShift[6:0], rxIn} : core_ff.rxShift;

    // master hands over after the gap, slave right on its last edge
    assign deliver = (core_ff.state == ST_GAP && core_ff.gapCnt == 2'(`USPI_GAP_CYCLES - 1))
        || (slvEdge && core_ff.edgeCnt == lastEdge);

    // register view for the apb slave
    assign regIf.ctrl = core_ff.ctrl;
    assign regIf.rxData = rightJust(core_ff.rxBuf, char8); // RULE_03
    assign regIf.stat = {3'h0, core_ff.state != ST_IDLE || core_ff.edgeCnt != 5'h00,
        core_ff.confl, core_ff.ovr, core_ff.rxDone, !core_ff.txFull};

    // next-state of the whole engine; flag sets come after clears so sets win
    always_comb
    begin
        nxt_core = core_ff;
        nxt_core.sclkPrev = sclkS;
        if (regIf.wrCtrl)
            nxt_core.ctrl = regIf.wdata;
        if (regIf.rdRx)
            nxt_core.rxDone = 1'b0; // RULE_22
        if (regIf.clrStat && regIf.wdata[`USPI_STAT_OVR])
            nxt_core.ovr = 1'b0;
        if (regIf.clrStat && regIf.wdata[`USPI_STAT_CONFL])
            nxt_core.confl = 1'b0;

        // common shift work for an edge in either role
        if (edgeEv)
        begin
            nxt_core.rxShift = rxNew; // RULE_07
            if (!sampleEdge(leading, cpha) && core_ff.edgeCnt != 5'h00)
                nxt_core.txShift = {core_ff.txShift[6:0], 1'b0}; // RULE_06 RULE_16
            nxt_core.edgeCnt = core_ff.edgeCnt + 5'h01;
        end

        case (core_ff.state)
            ST_IDLE:
            begin
                nxt_core.sclk = cpol;
                // a receive only starts by loading a character to send
                if (masterOn && linkEn && masterRun && core_ff.txFull)
                begin
                    nxt_core.txShift = core_ff.txBuf; // RULE_06 RULE_09
                    nxt_core.txFull = 1'b0; // RULE_21
                    nxt_core.state = ST_SHIFT;
                    nxt_core.divCnt = divVal;
                    nxt_core.edgeCnt = 5'h00;
                end
            end
            ST_SHIFT:
            begin
                // divider runs only while the bus is ours
                if (!masterRun)
                    nxt_core.divCnt = core_ff.divCnt;
                else if (tick)
                begin
                    nxt_core.sclk = !core_ff.sclk; // RULE_04 RULE_05
                    nxt_core.divCnt = divVal;
                end
                else
                    nxt_core.divCnt = core_ff.divCnt - 8'h01;
                if (charDone)
                begin
                    nxt_core.state = ST_GAP;
                    nxt_core.gapCnt = 2'h0;
                end
            end
            ST_GAP:
            begin
                // internal cycles only, shift clock stays parked
                nxt_core.gapCnt = core_ff.gapCnt + 2'h1; // RULE_10
                if (core_ff.gapCnt == 2'(`USPI_GAP_CYCLES - 1))
                begin
                    nxt_core.state = ST_IDLE;
                    nxt_core.edgeCnt = 5'h00;
                end
            end
            default:
                nxt_core.state = ST_IDLE;
        endcase

        // slave: preload before the clock starts, recycle on the last edge
        if (!isMaster)
        begin
            if (charDone)
            begin
                nxt_core.edgeCnt = 5'h00;
                nxt_core.shiftLoaded = 1'b0;
            end
            else if (!core_ff.shiftLoaded && core_ff.txFull && syncMode && linkEn && core_ff.edgeCnt == 5'h00)
            begin
                nxt_core.txShift = core_ff.txBuf; // RULE_16
                nxt_core.txFull = 1'b0; // RULE_21
                nxt_core.shiftLoaded = 1'b1;
            end
        end

        // leaving sync mode parks the engine
        if (!syncMode)
        begin
            nxt_core.state = ST_IDLE; // RULE_01
            nxt_core.edgeCnt = 5'h00;
            nxt_core.shiftLoaded = 1'b0;
        end

        // writes always land in the buffer slot, even a full one; overwrite is software's fault
        if (regIf.wrTx)
        begin
            nxt_core.txBuf = regIf.wdata[7:0];
            nxt_core.txFull = 1'b1; // RULE_21
        end

        // character hand-over; a slave's last edge may itself sample a bit
        if (deliver)
        begin
            nxt_core.rxBuf = rightJust(nxt_core.rxShift, char8); // RULE_02 RULE_07
            nxt_core.rxDone = 1'b1; // RULE_07
            if (core_ff.rxDone && !regIf.rdRx)
                nxt_core.ovr = 1'b1; // RULE_08
        end
        if (conflict)
        begin
            nxt_core.confl = 1'b1; // RULE_12
            nxt_core.rxDone = 1'b1; // RULE_12
        end

        // pin drive values follow from the next state, drive enables from the current control and select, so outputs are plain flops
        nxt_core.sclkOut = nxt_core.sclk;
        nxt_core.sclkOe = masterOn && masterRun; // RULE_12 RULE_13
        nxt_core.mosiOut = nxt_core.txShift[7]; // RULE_06 seven-bit characters use the top bits
        nxt_core.mosiOe = masterOn && masterRun; // RULE_12 RULE_13
        nxt_core.misoOut = nxt_core.mosiOut;
        nxt_core.misoOe = syncMode && !isMaster && linkEn && slaveSel; // RULE_19
    end

    // the only state register of the engine
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_ff <= '0;
            core_ff.ctrl <= `USPI_CTRL_RST;
        end
        else
            core_ff <= nxt_core;
    end

    assign sclkOut = core_ff.sclkOut;
    assign sclkOe = core_ff.sclkOe;
    assign mosiOut = core_ff.mosiOut;
    assign mosiOe = core_ff.mosiOe;
    assign misoOut = core_ff.misoOut;
    assign misoOe = core_ff.misoOe;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rx7_msb;
        !char8 |-> regIf.rxData[7] == 1'b0;
    endproperty
    a_rx7_msb: assert property (p_rx7_msb) else $error("seven-bit read shows top bit set"); // RULE_03

    property p_tx_load;
        core_ff.state == ST_IDLE && masterOn && linkEn && masterRun && core_ff.txFull && !regIf.wrTx
            |=> core_ff.state == ST_SHIFT && !core_ff.txFull;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("held character not moved to shifter"); // RULE_06

    property p_rx_done;
        deliver |=> core_ff.rxDone && core_ff.rxBuf == rightJust(core_ff.rxShift, $past(char8));
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("character not handed to receive buffer"); // RULE_07

    property p_overrun;
        deliver && core_ff.rxDone && !regIf.rdRx |=> core_ff.ovr;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RULE_08

    property p_gap;
        $rose(core_ff.state == ST_GAP) |=> (core_ff.state == ST_GAP && $stable(core_ff.sclk))
            ##1 (core_ff.state == ST_IDLE && $stable(core_ff.sclk));
    endproperty
    a_gap: assert property (p_gap) else $error("gap between characters is not two cycles"); // RULE_10

    property p_conflict;
        conflict |=> core_ff.confl && core_ff.rxDone && !sclkOe && !mosiOe;
    endproperty
    a_conflict: assert property (p_conflict) else $error("bus conflict not handled"); // RULE_12

    property p_restore;
        masterOn && masterRun |=> sclkOe && mosiOe;
    endproperty
    a_restore: assert property (p_restore) else $error("master drivers not restored"); // RULE_13

    property p_slv_release;
        syncMode && !isMaster && fourPin && steS |=> !misoOe;
    endproperty
    a_slv_release: assert property (p_slv_release) else $error("slave output driven while deselected"); // RULE_19

    property p_slv_freeze;
        syncMode && !isMaster && fourPin && steS && core_ff.state == ST_IDLE
            |=> core_ff.edgeCnt == $past(core_ff.edgeCnt);
    endproperty
    a_slv_freeze: assert property (p_slv_freeze) else $error("slave moved while deselected"); // RULE_18

    property p_rd_clear;
        regIf.rdRx && !deliver && !conflict |=> !core_ff.rxDone;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("receive done not cleared by read"); // RULE_22

    c_master_char: cover property (core_ff.state == ST_GAP ##1 deliver);
    c_slave_char: cover property (slvEdge && core_ff.edgeCnt == lastEdge);
    c_conflict: cover property (conflict);
    c_overrun: cover property (deliver && core_ff.rxDone);
endmodule
`default_nettype wire

// ### rtl/uspi_params.svh
`ifndef USPI_PARAMS_SVH
`define USPI_PARAMS_SVH
// register byte offsets on the apb bus
`define USPI_OFS_CTRL 8'h00
`define USPI_OFS_STAT 8'h04
`define USPI_OFS_TXBUF 8'h08
`define USPI_OFS_RXBUF 8'h0c
// control register fields
`define USPI_CTRL_SYNC 0
`define USPI_CTRL_MASTER 1
`define USPI_CTRL_CHAR8 2
`define USPI_CTRL_FOURPIN 3
`define USPI_CTRL_LINKEN 4
`define USPI_CTRL_CPOL 5
`define USPI_CTRL_CPHA 6
`define USPI_CTRL_DIV_LSB 8
`define USPI_CTRL_RST 16'h0404
// status register fields
`define USPI_STAT_TXE 0
`define USPI_STAT_RXDONE 1
`define USPI_STAT_OVR 2
`define USPI_STAT_CONFL 3
`define USPI_STAT_BUSY 4
// internal cycles between two master characters
`define USPI_GAP_CYCLES 2
// last edge index of a character, 7 and 8 bits
`define USPI_LAST_EDGE7 5'h0d
`define USPI_LAST_EDGE8 5'h0f
`endif

// ### rtl/uspi_pkg.sv
package uspi_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} uspi_state_e;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0] txBuf;
        logic txFull;
        logic [7:0] txShift;
        logic shiftLoaded;
        logic [7:0] rxShift;
        logic [7:0] rxBuf;
        logic rxDone;
        logic ovr;
        logic confl;
        uspi_state_e state;
        logic [7:0] divCnt;
        logic [4:0] edgeCnt;
        logic [1:0] gapCnt;
        logic sclk;
        logic sclkPrev;
        logic sclkOut;
        logic sclkOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
    } uspi_core_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } uspi_apb_s;
endpackage

// ### rtl/uspi_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
// register strobes between the apb slave and the engine core
interface uspi_reg_if;
    logic wrCtrl;
    logic wrTx;
    logic clrStat;
    logic rdRx;
    logic [15:0] wdata;
    logic [15:0] ctrl;
    logic [7:0] stat;
    logic [7:0] rxData;
    modport regs (output wrCtrl, wrTx, clrStat, rdRx, wdata, input ctrl, stat, rxData);
    modport core (input wrCtrl, wrTx, clrStat, rdRx, wdata, output ctrl, stat, rxData);
endinterface
`default_nettype wire

// ### rtl/uspi_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, one lane per pin
module uspi_sync #(
    parameter int W = 4
)(
    input wire logic ref_clk, // core clock
    input wire logic rst_n, // async reset
    input wire logic [W-1:0] d, // raw pins
    output logic [W-1:0] q // synchronised pins
);
    logic [W-1:0] meta_ff;
    genvar i;
    // first stage feeds only the second stage
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_ff[i] <= 1'b0;
                    q[i] <= 1'b0;
                end
                else
                begin
                    meta_ff[i] <= d[i];
                    q[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### rtl/uspi_apb.sv
`timescale 1ns/100ps
`default_nettype none
`include "uspi_params.svh"
// apb slave: one wait-free access, read data latched at setup
module uspi_apb
    import uspi_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic rst_n, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    uspi_reg_if.regs regIf // strobes to the core
);
    uspi_apb_s apb_ff;
    uspi_apb_s nxt_apb;
    logic take;

    function automatic logic isMapped(input logic [7:0] a);
        return a == `USPI_OFS_CTRL || a == `USPI_OFS_STAT || a == `USPI_OFS_TXBUF || a == `USPI_OFS_RXBUF;
    endfunction

    // strobes fire on the completing access edge only
    assign take = psel && penable && apb_ff.pready;
    assign regIf.wrCtrl = take && pwrite && paddr == `USPI_OFS_CTRL;
    assign regIf.clrStat = take && pwrite && paddr == `USPI_OFS_STAT;
    assign regIf.wrTx = take && pwrite && paddr == `USPI_OFS_TXBUF;
    assign regIf.rdRx = take && !pwrite && paddr == `USPI_OFS_RXBUF;
    assign regIf.wdata = pwdata[15:0];

    // ready rises in the access cycle; unmapped addresses answer with an error
    always_comb
    begin
        nxt_apb = apb_ff;
        nxt_apb.pready = psel && !penable;
        nxt_apb.pslverr = 1'b0;
        if (psel && !penable)
        begin
            nxt_apb.pslverr = !isMapped(paddr);
            case (paddr)
                `USPI_OFS_CTRL: nxt_apb.prdata = {16'h0000, regIf.ctrl};
                `USPI_OFS_STAT: nxt_apb.prdata = {24'h000000, regIf.stat};
                `USPI_OFS_RXBUF: nxt_apb.prdata = {24'h000000, regIf.rxData};
                default: nxt_apb.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            apb_ff <= '0;
        else
            apb_ff <= nxt_apb;
    end

    assign prdata = apb_ff.prdata;
    assign pready = apb_ff.pready;
    assign pslverr = apb_ff.pslverr;
endmodule
`default_nettype wire

// ### verif/uspi_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// far end: slave while the engine masters, master otherwise
module uspi_far_end (
    input wire logic isMaster, // far end owns the clock
    input wire logic sclkPin, // resolved shift clock
    input wire logic mosiPin, // resolved master-to-slave line
    input wire logic misoPin, // resolved slave-to-master line
    output logic sclkDrv, // clock driven as master
    output logic dataDrv // data bit driven, shifter msb
);
    logic [7:0] txByte;
    logic [7:0] rxByte;
    initial
    begin
        txByte = 8'h00;
        rxByte = 8'h00;
        sclkDrv = 1'b0;
    end
    assign dataDrv = txByte[7];
    // capture on the leading edge
    always @(posedge sclkPin)
    begin
        rxByte <= {rxByte[6:0], isMaster ? misoPin : mosiPin};
    end
    // launch on the trailing edge, so the first bit must sit ready
    always @(negedge sclkPin)
    begin
        txByte <= {txByte[6:0], 1'b0};
    end
    task automatic load(input logic [7:0] b);
        txByte = b;
        rxByte = 8'h00;
    endtask
    // clock stands still outside frames, 80 ns period inside
    task automatic clocks(input int n);
        #2; // keep link edges off the core clock edges
        repeat (n)
        begin
            #40 sclkDrv = 1'b1;
            #40 sclkDrv = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### verif/usart_spi_mode_engine_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "uspi_params.svh"
module usart_spi_mode_engine_tb_top;
    logic ref_clk, rst_n, psel, penable, pwrite, busSel, tgl, dutMaster, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
    wire logic sclkPin, mosiPin, misoPin, farSclk, farData;
    int failures, samples_checked, cyc;
    logic [31:0] expRx[$];
    uspi_engine i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclkIn(sclkPin), .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiIn(mosiPin), .mosiOut(mosiOut),
        .mosiOe(mosiOe), .misoIn(misoPin), .misoOut(misoOut), .misoOe(misoOe), .busSelIn(busSel));
    uspi_far_end i_far (.isMaster(!dutMaster), .sclkPin(sclkPin), .mosiPin(mosiPin), .misoPin(misoPin),
        .sclkDrv(farSclk), .dataDrv(farData));
    // released data lines toggle; a released clock rests low, its idle level
    assign sclkPin = sclkOe ? sclkOut : (dutMaster ? 1'b0 : farSclk);
    assign mosiPin = mosiOe ? mosiOut : (dutMaster ? tgl : farData);
    assign misoPin = misoOe ? misoOut : (dutMaster ? farData : tgl);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard, well above the whole sequence
    always @(posedge ref_clk)
    begin
        tgl <= ~tgl;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitBit(input int b);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `USPI_OFS_STAT, 32'h0);
            k++;
        end
        while (rd[b] !== 1'b1 && k < 200);
        if (k >= 200)
            failures++;
    endtask
    task automatic setSel(input logic v);
        @(posedge ref_clk);
        busSel <= v;
    endtask
    task automatic xfer(input logic [7:0] m, input logic [7:0] s, input logic b8, input logic go);
        if (go)
        begin
            i_far.load(s);
            expRx.push_back(b8 ? s : s >> 1);
            apb(1'b1, `USPI_OFS_TXBUF, {24'h0, m});
        end
        waitBit(1);
        chk("far rx", b8 ? m : m >> 1, i_far.rxByte);
        apb(1'b0, `USPI_OFS_RXBUF, 32'h0);
        chk("rxbuf", expRx.pop_front(), rd);
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("done clear", 1'b0, rd[1]);
    endtask
    // engine as slave; split pauses mid-character with select high
    task automatic sxfer(input logic [7:0] m, input logic [7:0] s, input logic split);
        apb(1'b1, `USPI_OFS_TXBUF, {24'h0, s});
        i_far.load(m);
        expRx.push_back(m);
        repeat (4) @(posedge ref_clk);
        i_far.clocks(split ? 4 : 8);
        if (split)
        begin
            setSel(1'b1);
            repeat (10) @(posedge ref_clk);
            chk("miso released", 1'b0, misoOe);
            setSel(1'b0);
            repeat (4) @(posedge ref_clk);
            i_far.clocks(4);
        end
        xfer(s, m, 1'b1, 1'b0);
    endtask
    task automatic wrap_up;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, tgl, dutMaster, er, rd} = '0;
        {failures, samples_checked, cyc} = '0;
        busSel = 1'b1;
        rst_n = 1'b0;
        void'($urandom(98));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `USPI_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0404, rd);
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("stat reset", 32'h1, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        dutMaster <= 1'b1;
        apb(1'b1, `USPI_OFS_CTRL, 32'h0317);
        repeat (4) xfer(8'($urandom), 8'($urandom), 1'b1, 1'b1);
        // back-to-back characters, second held, no read between
        i_far.load(8'h3c);
        apb(1'b1, `USPI_OFS_TXBUF, 32'h11);
        apb(1'b1, `USPI_OFS_TXBUF, 32'h22);
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("txe held", 1'b0, rd[0]);
        waitBit(2);
        chk("overrun", 1'b1, rd[2]);
        waitBit(4 - 4 + 1);
        repeat (10) @(posedge ref_clk);
        chk("far rx 2nd", 8'h22, i_far.rxByte);
        apb(1'b0, `USPI_OFS_RXBUF, 32'h0);
        chk("rxbuf 2nd", 32'h0, rd);
        apb(1'b1, `USPI_OFS_STAT, 32'h4);
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("ovr cleared", 1'b0, rd[2]);
        apb(1'b1, `USPI_OFS_CTRL, 32'h0313);
        repeat (2) xfer(8'($urandom), 8'($urandom), 1'b0, 1'b1);
        // link off: nothing moves until it is set again
        apb(1'b1, `USPI_OFS_CTRL, 32'h0307);
        i_far.load(8'h96);
        expRx.push_back(32'h96);
        apb(1'b1, `USPI_OFS_TXBUF, 32'h69);
        repeat (100) @(posedge ref_clk);
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("link off", 4'h0, rd[4:1]);
        apb(1'b1, `USPI_OFS_CTRL, 32'h0317);
        xfer(8'h69, 8'h96, 1'b1, 1'b0);
        // four-pin master, another master pulls select low
        apb(1'b1, `USPI_OFS_CTRL, 32'h031f);
        setSel(1'b0);
        repeat (6) @(posedge ref_clk);
        chk("drivers off", 2'b00, {sclkOe, mosiOe});
        apb(1'b0, `USPI_OFS_STAT, 32'h0);
        chk("conflict", 2'b11, {rd[3], rd[1]});
        setSel(1'b1);
        repeat (6) @(posedge ref_clk);
        chk("drivers back", 2'b11, {sclkOe, mosiOe});
        apb(1'b1, `USPI_OFS_STAT, 32'h8);
        apb(1'b0, `USPI_OFS_RXBUF, 32'h0);
        xfer(8'($urandom), 8'($urandom), 1'b1, 1'b1);
        apb(1'b1, `USPI_OFS_CTRL, 32'h0317);
        setSel(1'b0);
        xfer(8'($urandom), 8'($urandom), 1'b1, 1'b1);
        dutMaster <= 1'b0;
        apb(1'b1, `USPI_OFS_CTRL, 32'h0315);
        setSel(1'b1);
        repeat (2) sxfer(8'($urandom), 8'($urandom), 1'b0);
        apb(1'b1, `USPI_OFS_CTRL, 32'h031d);
        repeat (6) @(posedge ref_clk);
        chk("slave idle off", 1'b0, misoOe);
        setSel(1'b0);
        sxfer(8'($urandom), 8'($urandom), 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
